// [src/ep_cfg_pkg.sv]
// constants for the endpoint select and configuration block
// assumes an 8-bit special-function register port from the core
package ep_cfg_pkg;
   localparam int          DATA_W         = 8;
   localparam int          ADDR_W         = 8;
   localparam int          EP_COUNT       = 4;
   localparam int          EP_IDX_W       = 2;
   localparam logic [7:0]  ADDR_EP_INDEX  = 8'hC7;
   localparam logic [7:0]  ADDR_EP_CTRL   = 8'hD4;
   localparam logic [7:0]  ADDR_EP_STATUS = 8'hCE;
   localparam logic [7:0]  RESET_BYTE     = 8'h00;
   localparam int          BIT_EP_ON      = 7;
   localparam int          BIT_NAK_IRQ_ON = 6;
   localparam int          BIT_NAK_OUT    = 5;
   localparam int          BIT_NAK_IN     = 4;
   localparam int          BIT_TOGGLE     = 3;
   localparam int          BIT_DIR        = 2;
   localparam int          TYPE_MSB       = 1;
   localparam int          TYPE_LSB       = 0;
   // writable bits of the control byte; flags and toggle handled apart
   localparam logic [7:0]  CTRL_RW_MASK   = 8'hC7;
   typedef enum logic [1:0] {
      TYPE_CONTROL = 2'h0,
      TYPE_ISO     = 2'h1,
      TYPE_BULK    = 2'h2,
      TYPE_INTR    = 2'h3
   } ep_kind_type;
endpackage : ep_cfg_pkg

// [src/ep_cfg_bank.sv]
// four-entry bank of control bytes, one per endpoint, registered read
// assumes one writer; write and read on the same clock
`timescale 1ns/1ps
module ep_cfg_bank
   import ep_cfg_pkg::*;
#(
   parameter int DEPTH = EP_COUNT,
   parameter int AW    = EP_IDX_W
) (
   input  wire logic              CLOCK_IN,  // controller clock
   input  wire logic              RESET_IN,  // sync reset, high
   input  wire logic [DEPTH-1:0]  WE_IN,     // per-entry write
   input  wire logic [DEPTH*8-1:0] WDATA_IN, // per-entry next value
   input  wire logic [AW-1:0]     RADDR_IN,  // read select
   output logic [7:0]             RDATA_OUT, // registered read data
   output logic [DEPTH*8-1:0]     ALL_OUT    // every entry, flat
);
   logic [7:0] mem_r [DEPTH];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : gen_ent
         always_ff @(posedge CLOCK_IN) begin
            if (RESET_IN) begin
               mem_r[g] <= RESET_BYTE;
            end else if (WE_IN[g]) begin
               mem_r[g] <= WDATA_IN[g*8 +: 8];
            end
         end
         assign ALL_OUT[g*8 +: 8] = mem_r[g];
      end
   endgenerate

   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         RDATA_OUT <= RESET_BYTE;
      end else begin
         RDATA_OUT <= mem_r[RADDR_IN];
      end
   end
endmodule : ep_cfg_bank

// [src/usb_endpoint_select_config.sv]
// endpoint index register and indexed per-endpoint control registers
// assumes the core drives an 8-bit register port, one access per cycle;
// packet engines report naks and data pids as one-cycle pulses
`timescale 1ns/1ps
// Functional notes
// R01 - two-bit index in low bits picks which endpoint registers respond
// R02 - upper six index bits read zero; firmware never writes ones there
// R03 - control bit 7 enables the selected endpoint
// R04 - firmware enables endpoint zero after every hardware or bus reset
// R05 - bit 6 lets either nak flag raise the usb interrupt
// R06 - bit 5 set on nak to host out; software clears it
// R07 - bit 4 set on nak to host in; software clears it
// R08 - bit 3 read-only toggle: set on data1, cleared on data0
// R09 - bit 2 gives direction for non-control types, ignored for control
// R10 - low two bits choose control, isochronous, bulk or interrupt type
// R11 - firmware always programs endpoint zero as control type
// R12 - status register is also selected by the current index
// R13 - each of the four endpoints keeps its own control byte
module usb_endpoint_select_config
   import ep_cfg_pkg::*;
#(
   parameter int NUM_EP = EP_COUNT
) (
   input  wire logic              CLOCK_IN,       // controller clock
   input  wire logic              RESET_IN,       // sync reset, high
   input  wire logic              BUS_RESET_IN,   // usb bus reset pulse
   input  wire logic [7:0]        ADDR_IN,        // register address
   input  wire logic              WR_IN,          // write strobe
   input  wire logic              RD_IN,          // read strobe
   input  wire logic [7:0]        WDATA_IN,       // write data
   output logic [7:0]             RDATA_OUT,      // read data, registered
   output logic                   HIT_OUT,        // address is ours
   input  wire logic [NUM_EP-1:0] NAK_OUT_EV_IN,  // nak sent to host out
   input  wire logic [NUM_EP-1:0] NAK_IN_EV_IN,   // nak sent to host in
   input  wire logic [NUM_EP-1:0] DATA1_EV_IN,    // data1 received
   input  wire logic [NUM_EP-1:0] DATA0_EV_IN,    // data0 received
   output logic [NUM_EP-1:0]      EP_ON_OUT,      // endpoint enabled
   output logic [NUM_EP-1:0]      EP_IS_IN_OUT,   // effective direction in
   output logic [NUM_EP*2-1:0]    EP_KIND_OUT,    // type field per ep
   output logic [NUM_EP-1:0]      TOGGLE_OUT,     // data toggle per ep
   output logic [1:0]             STATUS_SEL_OUT, // index for status reg
   output logic                   STATUS_HIT_OUT, // status reg access
   output logic                   NAK_IRQ_OUT     // nak interrupt request
);
   logic [EP_IDX_W-1:0] endpoint_index_field_r;
   logic [NUM_EP-1:0]   we;
   logic [NUM_EP-1:0]   irq_on;
   logic [NUM_EP-1:0]   nak_pend;
   logic [NUM_EP*8-1:0] wdata_all;
   logic [NUM_EP*8-1:0] all_bytes;
   logic [7:0]          bank_rdata;
   logic                sel_idx_r;
   logic                sel_ctrl_r;
   logic                wr_ctrl;
   logic                clr;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction : hit

   assign wr_ctrl = WR_IN && hit(ADDR_IN, ADDR_EP_CTRL);
   // a bus reset drops configuration the same as a hardware reset
   assign clr     = RESET_IN || BUS_RESET_IN;

   // index register; reserved bits are simply not stored
   always_ff @(posedge CLOCK_IN) begin
      if (clr) begin
         endpoint_index_field_r <= '0;
      end else if (WR_IN && hit(ADDR_IN, ADDR_EP_INDEX)) begin
         endpoint_index_field_r <= WDATA_IN[EP_IDX_W-1:0]; // [R01]
      end
   end

   // per-endpoint next value: firmware writes rw bits, flags follow events;
   // an event in the clearing cycle wins so no nak is lost
   genvar e;
   generate
      for (e = 0; e < NUM_EP; e++) begin : gen_ep
         logic [7:0] cur;
         logic       sel;
         logic [7:0] nxt;
         assign cur = all_bytes[e*8 +: 8];
         assign sel = wr_ctrl && (endpoint_index_field_r == EP_IDX_W'(e));
         always_comb begin
            nxt = cur;
            if (sel) begin
               nxt = (cur & ~CTRL_RW_MASK) | (WDATA_IN & CTRL_RW_MASK);
               nxt[BIT_NAK_OUT] = WDATA_IN[BIT_NAK_OUT] & cur[BIT_NAK_OUT];
               nxt[BIT_NAK_IN]  = WDATA_IN[BIT_NAK_IN] & cur[BIT_NAK_IN];
            end
            if (NAK_OUT_EV_IN[e]) begin
               nxt[BIT_NAK_OUT] = 1'b1; // [R06]
            end
            if (NAK_IN_EV_IN[e]) begin
               nxt[BIT_NAK_IN] = 1'b1; // [R07]
            end
            if (DATA1_EV_IN[e]) begin
               nxt[BIT_TOGGLE] = 1'b1; // [R08]
            end else if (DATA0_EV_IN[e]) begin
               nxt[BIT_TOGGLE] = 1'b0; // [R08]
            end
         end
         assign we[e] = sel || NAK_OUT_EV_IN[e] || NAK_IN_EV_IN[e]
                        || DATA1_EV_IN[e] || DATA0_EV_IN[e];
         assign wdata_all[e*8 +: 8] = nxt;
         assign EP_ON_OUT[e]  = cur[BIT_EP_ON]; // [R03]
         assign EP_KIND_OUT[e*2 +: 2] = cur[TYPE_MSB:TYPE_LSB]; // [R10]
         // control endpoints ignore the direction bit
         assign EP_IS_IN_OUT[e] = (cur[TYPE_MSB:TYPE_LSB] != TYPE_CONTROL)
                                  && cur[BIT_DIR]; // [R09]
         assign TOGGLE_OUT[e] = cur[BIT_TOGGLE];
         assign irq_on[e]   = cur[BIT_NAK_IRQ_ON];
         assign nak_pend[e] = cur[BIT_NAK_OUT] || cur[BIT_NAK_IN];

         // flags and toggle are checked on every endpoint, not only ep0
         chk_nak_out_sets: assert property ( // [R06]
            @(posedge CLOCK_IN) disable iff (clr)
            NAK_OUT_EV_IN[e] |=> cur[BIT_NAK_OUT])
            else $error("nak out flag not set");

         chk_nak_in_sets: assert property ( // [R07]
            @(posedge CLOCK_IN) disable iff (clr)
            NAK_IN_EV_IN[e] |=> cur[BIT_NAK_IN])
            else $error("nak in flag not set");

         chk_toggle_follows: assert property ( // [R08]
            @(posedge CLOCK_IN) disable iff (clr)
            (DATA0_EV_IN[e] && !DATA1_EV_IN[e]) |=> !cur[BIT_TOGGLE])
            else $error("toggle not cleared on data0");

         chk_toggle_sets: assert property ( // [R08]
            @(posedge CLOCK_IN) disable iff (clr)
            DATA1_EV_IN[e] |=> cur[BIT_TOGGLE])
            else $error("toggle not set on data1");
      end
   endgenerate

   ep_cfg_bank #(
      .DEPTH (NUM_EP),
      .AW    (EP_IDX_W)
   ) u_bank (
      .CLOCK_IN  (CLOCK_IN),
      .RESET_IN  (clr),
      .WE_IN     (we),
      .WDATA_IN  (wdata_all),
      .RADDR_IN  (endpoint_index_field_r), // [R13]
      .RDATA_OUT (bank_rdata),
      .ALL_OUT   (all_bytes)
   );

   // interrupt: any endpoint with enable and a pending nak flag
   always_ff @(posedge CLOCK_IN) begin
      if (clr) begin
         NAK_IRQ_OUT <= 1'b0;
      end else begin
         NAK_IRQ_OUT <= 1'b0;
         for (int i = 0; i < NUM_EP; i++) begin
            if (all_bytes[i*8+BIT_NAK_IRQ_ON]
                && (all_bytes[i*8+BIT_NAK_OUT] || all_bytes[i*8+BIT_NAK_IN]))
            begin
               NAK_IRQ_OUT <= 1'b1; // [R05]
            end
         end
      end
   end

   // read path: bank read is one cycle late, so the select is delayed too
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         sel_idx_r  <= 1'b0;
         sel_ctrl_r <= 1'b0;
      end else begin
         sel_idx_r  <= RD_IN && hit(ADDR_IN, ADDR_EP_INDEX);
         sel_ctrl_r <= RD_IN && hit(ADDR_IN, ADDR_EP_CTRL);
      end
   end

   always_comb begin
      RDATA_OUT = 8'h00;
      if (sel_idx_r) begin
         RDATA_OUT = {6'h00, endpoint_index_field_r}; // [R02]
      end else if (sel_ctrl_r) begin
         RDATA_OUT = bank_rdata; // [R01]
      end
   end

   assign HIT_OUT = hit(ADDR_IN, ADDR_EP_INDEX) || hit(ADDR_IN, ADDR_EP_CTRL);
   assign STATUS_SEL_OUT = endpoint_index_field_r; // [R12]
   assign STATUS_HIT_OUT = (RD_IN || WR_IN)
                           && hit(ADDR_IN, ADDR_EP_STATUS); // [R12]

   chk_index_upper_zero: assert property ( // [R02]
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      sel_idx_r |-> RDATA_OUT[7:2] == 6'h00)
      else $error("index upper bits not zero");

   // no endpoint with both enable and a pending flag: line must drop
   chk_irq_gated: assert property ( // [R05]
      @(posedge CLOCK_IN) disable iff (clr)
      ((irq_on & nak_pend) == '0) |=> !NAK_IRQ_OUT)
      else $error("irq without enable");

   chk_irq_raised: assert property ( // [R05]
      @(posedge CLOCK_IN) disable iff (clr)
      (|(irq_on & nak_pend)) |=> NAK_IRQ_OUT)
      else $error("irq missing for enabled nak");

   chk_ctrl_read_sel: assert property ( // [R01]
      @(posedge CLOCK_IN) disable iff (clr)
      (RD_IN && hit(ADDR_IN, ADDR_EP_CTRL) && !(|we))
      |=> RDATA_OUT == all_bytes[endpoint_index_field_r*8 +: 8])
      else $error("control read wrong endpoint");

   chk_enable_write: assert property ( // [R03]
      @(posedge CLOCK_IN) disable iff (clr)
      (wr_ctrl && endpoint_index_field_r == 2'h0)
      |=> EP_ON_OUT[0] == $past(WDATA_IN[BIT_EP_ON]))
      else $error("enable bit not written");

   chk_dir_control: assert property ( // [R09]
      @(posedge CLOCK_IN) disable iff (clr)
      EP_KIND_OUT[1:0] == TYPE_CONTROL |-> !EP_IS_IN_OUT[0])
      else $error("direction used on control");
endmodule : usb_endpoint_select_config

// [sim/usb_host_events.sv]
// far-side stand-in: packet engines reporting handshakes and data pids
// assumes the caller is just past a rising edge when it calls send
`timescale 1ns/1ps
module usb_host_events (
   input  wire logic  CLOCK_IN,       // controller clock
   output logic [3:0] NAK_OUT_EV_OUT, // nak sent to host out
   output logic [3:0] NAK_IN_EV_OUT,  // nak sent to host in
   output logic [3:0] DATA1_EV_OUT,   // data1 received
   output logic [3:0] DATA0_EV_OUT    // data0 received
);
   initial begin
      NAK_OUT_EV_OUT = 4'h0;
      NAK_IN_EV_OUT  = 4'h0;
      DATA1_EV_OUT   = 4'h0;
      DATA0_EV_OUT   = 4'h0;
   end
   // one-cycle pulse; kind 0 nak-out, 1 nak-in, 2 data1, 3 data0
   task automatic send(input int kind, input logic [3:0] eps);
      case (kind)
         0: NAK_OUT_EV_OUT = eps;
         1: NAK_IN_EV_OUT = eps;
         2: DATA1_EV_OUT = eps;
         default: DATA0_EV_OUT = eps;
      endcase
      @(posedge CLOCK_IN);
      #1;
      NAK_OUT_EV_OUT = 4'h0;
      NAK_IN_EV_OUT  = 4'h0;
      DATA1_EV_OUT   = 4'h0;
      DATA0_EV_OUT   = 4'h0;
   endtask : send
endmodule : usb_host_events

// [sim/tb_usb_endpoint_select_config.sv]
// self-checking bench for the endpoint select and control registers
// assumes one register access per cycle, inputs moved 1 ns after edges
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
   n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_usb_endpoint_select_config;
   import ep_cfg_pkg::*;
   logic       clk, rst, bus_rst, wr, rd, hit, st_hit, irq;
   logic [7:0] addr, wdata, rdata, kind;
   logic [3:0] nko, nki, d1, d0, on, is_in, tgl;
   logic [1:0] st_sel;
   int         n_errors, checks_done;
   usb_endpoint_select_config usb_endpoint_select_config_i (
      .CLOCK_IN(clk), .RESET_IN(rst), .BUS_RESET_IN(bus_rst),
      .ADDR_IN(addr), .WR_IN(wr), .RD_IN(rd), .WDATA_IN(wdata),
      .RDATA_OUT(rdata), .HIT_OUT(hit), .NAK_OUT_EV_IN(nko),
      .NAK_IN_EV_IN(nki), .DATA1_EV_IN(d1), .DATA0_EV_IN(d0),
      .EP_ON_OUT(on), .EP_IS_IN_OUT(is_in), .EP_KIND_OUT(kind),
      .TOGGLE_OUT(tgl), .STATUS_SEL_OUT(st_sel),
      .STATUS_HIT_OUT(st_hit), .NAK_IRQ_OUT(irq));
   usb_host_events usb_host_events_i (
      .CLOCK_IN(clk), .NAK_OUT_EV_OUT(nko), .NAK_IN_EV_OUT(nki),
      .DATA1_EV_OUT(d1), .DATA0_EV_OUT(d0));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // one cycle of the register port; returns 1 ns past the taking edge
   task automatic acc(input logic w, r, input logic [7:0] a, d);
      wr    = w;
      rd    = r;
      addr  = a;
      wdata = d;
      @(posedge clk);
      #1;
   endtask : acc
   task automatic wr_reg(input logic [7:0] a, d);
      acc(1'b1, 1'b0, a, d);
   endtask : wr_reg
   // read data stands for the one cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, exp);
      acc(1'b0, 1'b1, a, 8'h00);
      `CHK(rdata, exp)
   endtask : rd_chk
   task automatic end_sim;
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   initial begin
      #5000;
      n_errors++;
      end_sim;
   end
   initial begin
      n_errors = 0;
      checks_done = 0;
      rst = 1'b1;
      bus_rst = 1'b0;
      {wr, rd, addr, wdata} = 18'h0;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      rd_chk(ADDR_EP_INDEX, 8'h00);
      rd_chk(ADDR_EP_CTRL, 8'h00);
      // index write of 3 reads back; status select follows it
      wr_reg(ADDR_EP_INDEX, 8'h03);
      rd_chk(ADDR_EP_INDEX, 8'h03);
      `CHK(hit, 1'b1)
      `CHK(st_hit, 1'b0)
      `CHK(st_sel, 2'h3)
      rd_chk(ADDR_EP_STATUS, 8'h00);
      `CHK(st_hit, 1'b1)
      `CHK(hit, 1'b0)
      // every endpoint gets its own type; ep0 control with dir set
      for (int e = 0; e < 4; e++) begin
         wr_reg(ADDR_EP_INDEX, 8'(e));
         wr_reg(ADDR_EP_CTRL, 8'hBC | 8'(e));
      end
      for (int e = 0; e < 4; e++) begin
         wr_reg(ADDR_EP_INDEX, 8'(e));
         rd_chk(ADDR_EP_CTRL, 8'h84 | 8'(e));
         `CHK(kind[2*e +: 2], 2'(e))
         `CHK(is_in[e], (e != 0))
      end
      `CHK(on, 4'hF)
      wr_reg(ADDR_EP_CTRL, 8'h07);
      `CHK(on, 4'h7)
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      `CHK(on, 4'h7)
      // toggle tracks data pids on ep2 only
      usb_host_events_i.send(2, 4'h4);
      `CHK(tgl, 4'h4)
      wr_reg(ADDR_EP_INDEX, 8'h02);
      rd_chk(ADDR_EP_CTRL, 8'h8E);
      usb_host_events_i.send(3, 4'h4);
      `CHK(tgl, 4'h0)
      // nak flag without enable raises nothing
      usb_host_events_i.send(0, 4'h4);
      rd_chk(ADDR_EP_CTRL, 8'hA6);
      `CHK(irq, 1'b0)
      wr_reg(ADDR_EP_CTRL, 8'hE6);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      `CHK(irq, 1'b1)
      wr_reg(ADDR_EP_CTRL, 8'hC6);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      `CHK(irq, 1'b0)
      usb_host_events_i.send(1, 4'h4);
      rd_chk(ADDR_EP_CTRL, 8'hD6);
      `CHK(irq, 1'b1)
      wr_reg(ADDR_EP_CTRL, 8'h86);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      `CHK(irq, 1'b0)
      rd_chk(8'h55, 8'h00);
      // bus reset wipes index and all endpoints
      bus_rst = 1'b1;
      @(posedge clk);
      #1;
      bus_rst = 1'b0;
      `CHK(on, 4'h0)
      rd_chk(ADDR_EP_INDEX, 8'h00);
      rd_chk(ADDR_EP_CTRL, 8'h00);
      // firmware brings endpoint zero back up as control after bus reset
      wr_reg(ADDR_EP_CTRL, 8'h80);
      rd_chk(ADDR_EP_CTRL, 8'h80);
      `CHK(on, 4'h1)
      `CHK(kind[1:0], 2'h0)
      end_sim;
   end
endmodule : tb_usb_endpoint_select_config
